// [rtl/pgi_port_ctrl.sv]
// port l pin control and filtered edge interrupts of ports g, h, j
`timescale 1ns/10ps
// What this block does
// - direction bit one makes pin output
// - led enable forces five low pins output
// - readback lags direction change two cycles
// - reduced drive bit only for outputs
// - pull only for input or open drain
// - port l pulls reset as pull-ups
// - polarity one pull-down on inputs only, zero pull-up
// - open drain drives only low
// - latch read muxes pin or latch
// - latch reaches pin only as output
// - input register always returns pins
// - owning peripheral overrides direction
// - port g per-pin edge interrupts, one vector
// - flag and enable raise wake request
// - four passive then four active samples
// - stop filter rejects 3.2us, accepts 10us
// - bus clock in run, rc in stop
// - rc runs only while a pin waits
// - port h has same edge interrupts
// - two-wire makes upper j pins open drain
// - reset states: j upper and port l pull-up, others hiz
// - stop mode still raises interrupts
// - registers other than the read-only input register writable at any time
// - edge sets flag, write one clears
// - polarity one rising, zero falling
module pgi_port_ctrl
    import pgi_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic [6:0]  l_pin_in,
    output pgi_pad_t         l_pad,
    input  wire logic [6:0]  l_periph_own,
    input  wire logic [6:0]  l_periph_out,
    input  wire logic [6:0]  l_periph_oe,
    input  wire logic        status_led_enable,
    input  wire logic [4:0]  led_pins,
    input  wire logic [7:0]  g_pin_in,
    input  wire logic [6:0]  h_pin_in,
    input  wire logic [7:0]  j_pin_in,
    input  wire logic        two_wire_en,
    input  wire logic [1:0]  two_wire_drive_low,
    output logic [1:0]       port_j_upper_oe,
    output logic [1:0]       port_j_upper_pull_up,
    input  wire logic        stop_mode,
    output logic             rc_osc_run,
    output logic             irq_g,
    output logic             irq_h,
    output logic             irq_j,
    output logic             wake_request
);

    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    logic            a_valid;
    logic            a_write;
    logic [7:0]      a_addr;
    logic            rd_wait;
    logic            wr_en;
    logic [6:0]      latch;
    logic [6:0]      dir;
    logic [6:0]      rdr;
    logic [6:0]      pe;
    logic [6:0]      edge_polarity_select;
    logic [6:0]      od;
    logic [6:0]      l_meta;
    logic [6:0]      l_sync;
    logic [2:0][7:0] irq_meta;
    logic [2:0][7:0] irq_sync;
    logic [2:0][7:0] en;
    logic [2:0][7:0] pol;
    logic [2:0][7:0] flag;
    logic [2:0][7:0] edge_hit;
    logic [7:0]      rc_cnt;
    logic            tick;
    logic [31:0]     next_rdata;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            a_valid <= 1'b0;
            a_write <= 1'b0;
            a_addr  <= 8'h00;
        end else if (hready) begin
            a_valid <= hsel & htrans[1];
            a_write <= hwrite;
            a_addr  <= haddr[7:0];
        end
    end

    // reads take one wait state so a write just before is seen
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_wait <= 1'b0;
        end else begin
            rd_wait <= hready & hsel & htrans[1] & ~hwrite;
        end
    end

    assign hreadyout = ~rd_wait;
    assign hresp     = 1'b0;
    assign wr_en     = a_valid & a_write & ~rd_wait;

    always_comb begin
        next_rdata = 32'h0000_0000;
        case (a_addr)
            OFF_L_LATCH: next_rdata[6:0] = (dir & latch) | (~dir & l_sync);
            OFF_L_INPUT: next_rdata[6:0] = l_sync;
            OFF_L_DIR:   next_rdata[6:0] = dir;
            OFF_L_DRIVE: next_rdata[6:0] = rdr;
            OFF_L_PE:    next_rdata[6:0] = pe;
            OFF_L_PPS:   next_rdata[6:0] = edge_polarity_select;
            OFF_L_OD:    next_rdata[6:0] = od;
            default: begin
                for (int p = 0; p < 3; p++) begin
                    if (hit(a_addr, OFF_IRQ_EN + 8'(p * 16))) next_rdata[7:0] = en[p];
                    if (hit(a_addr, OFF_IRQ_POL + 8'(p * 16))) next_rdata[7:0] = pol[p];
                    if (hit(a_addr, OFF_IRQ_FLG + 8'(p * 16))) next_rdata[7:0] = flag[p];
                end
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_wait) begin
            hrdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // port l configuration, writable at any time
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            latch <= 7'h00;
            dir   <= 7'h00;
            rdr   <= 7'h00;
            pe    <= L_PE_RST;
            edge_polarity_select   <= 7'h00;
            od    <= 7'h00;
        end else if (wr_en) begin
            if (hit(a_addr, OFF_L_LATCH)) latch <= hwdata[6:0];
            if (hit(a_addr, OFF_L_DIR))   dir   <= hwdata[6:0];
            if (hit(a_addr, OFF_L_DRIVE)) rdr   <= hwdata[6:0];
            if (hit(a_addr, OFF_L_PE))    pe    <= hwdata[6:0];
            if (hit(a_addr, OFF_L_PPS))   edge_polarity_select   <= hwdata[6:0];
            if (hit(a_addr, OFF_L_OD))    od    <= hwdata[6:0];
        end
    end

    // pin levels pass two flops, so readback trails a direction change
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            l_meta   <= 7'h00;
            l_sync   <= 7'h00;
            irq_meta <= '0;
            irq_sync <= '0;
        end else begin
            l_meta   <= l_pin_in;
            l_sync   <= l_meta;
            irq_meta <= {j_pin_in, 1'b0, h_pin_in, g_pin_in};
            irq_sync <= irq_meta;
        end
    end

    // ------------------------------------------------------------
    // port l pad control
    // ------------------------------------------------------------
    logic [6:0] own;
    logic [6:0] led_own;
    logic [6:0] dir_eff;
    logic [6:0] out_eff;
    logic [6:0] od_eff;
    logic [6:0] pull_on;

    assign led_own = status_led_enable ? LED_MASK : 7'h00;
    assign own     = l_periph_own & ~led_own;
    always_comb begin
        dir_eff = (own & l_periph_oe) | (~own & dir);
        dir_eff = dir_eff | led_own;
        out_eff = (own & l_periph_out) | (~own & latch);
        out_eff = (out_eff & ~led_own) | (led_own & {2'b00, led_pins});
    end
    // peripherals and leds drive push-pull; open drain is a gpio option
    assign od_eff  = od & ~own & ~led_own;
    assign pull_on = pe & (~dir_eff | od_eff);

    always_comb begin
        l_pad.oe        = dir_eff & ~(od_eff & out_eff);
        l_pad.out       = out_eff & ~od_eff;
        l_pad.reduced   = rdr & dir_eff;
        l_pad.pull_up   = pull_on & ~edge_polarity_select;
        l_pad.pull_down = pull_on & edge_polarity_select & ~dir_eff;
    end

    // ------------------------------------------------------------
    // port j upper pins
    // ------------------------------------------------------------
    // low only, so the bus can be shared with other open drains
    assign port_j_upper_oe      = two_wire_en ? two_wire_drive_low : 2'b00;
    assign port_j_upper_pull_up = two_wire_en ? 2'b00 : 2'b11;

    // ------------------------------------------------------------
    // filter clock: every bus cycle in run, divided rc tick in stop
    // ------------------------------------------------------------
    assign rc_osc_run = stop_mode & |(en & ~flag & IRQ_MASK);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rc_cnt <= 8'h00;
        end else if (!rc_osc_run || rc_cnt == 8'(RC_DIV - 1)) begin
            rc_cnt <= 8'h00;
        end else begin
            rc_cnt <= rc_cnt + 8'h01;
        end
    end

    // rc tick of 2us puts four samples between 3.2us and 10us
    assign tick = ~stop_mode | (rc_osc_run & rc_cnt == 8'(RC_DIV - 1));

    // ------------------------------------------------------------
    // edge filters
    // ------------------------------------------------------------
    for (genvar gp = 0; gp < 3; gp++) begin : g_port
        for (genvar gb = 0; gb < 8; gb++) begin : g_pin
            logic [2:0] pcnt;
            logic [2:0] acnt;
            logic       act;
            assign act = irq_sync[gp][gb] ~^ pol[gp][gb];
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    pcnt <= 3'h0;
                    acnt <= 3'h0;
                end else if (tick) begin
                    if (!act) begin
                        acnt <= 3'h0;
                        if (pcnt != 3'(FILT_N)) pcnt <= pcnt + 3'h1;
                    end else if (pcnt == 3'(FILT_N)) begin
                        if (acnt == 3'(FILT_N - 1)) begin
                            pcnt <= 3'h0;
                            acnt <= 3'h0;
                        end else begin
                            acnt <= acnt + 3'h1;
                        end
                    end else begin
                        pcnt <= 3'h0;
                    end
                end
            end
            assign edge_hit[gp][gb] = tick & act & IRQ_MASK[gp][gb]
                                    & pcnt == 3'(FILT_N) & acnt == 3'(FILT_N - 1);
        end

        // set wins over a write-one clear in the same cycle
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                en[gp]   <= 8'h00;
                pol[gp]  <= 8'h00;
                flag[gp] <= 8'h00;
            end else begin
                if (wr_en && hit(a_addr, OFF_IRQ_EN + 8'(gp * 16))) begin
                    en[gp] <= hwdata[7:0] & IRQ_MASK[gp];
                end
                if (wr_en && hit(a_addr, OFF_IRQ_POL + 8'(gp * 16))) begin
                    pol[gp] <= hwdata[7:0] & IRQ_MASK[gp];
                end
                if (wr_en && hit(a_addr, OFF_IRQ_FLG + 8'(gp * 16))) begin
                    flag[gp] <= (flag[gp] & ~hwdata[7:0]) | edge_hit[gp];
                end else begin
                    flag[gp] <= flag[gp] | edge_hit[gp];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // interrupt outputs, one per port, combinational from flags
    // ------------------------------------------------------------
    assign irq_g        = |(flag[0] & en[0]);
    assign irq_h        = |(flag[1] & en[1]);
    assign irq_j        = |(flag[2] & en[2]);
    assign wake_request = irq_g | irq_h | irq_j;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    chk_flag_on_edge: assert property (
        edge_hit[0] != 8'h00 |=> (flag[0] & $past(edge_hit[0])) == $past(edge_hit[0]))
        else $error("edge did not set flag");
    chk_w1c_clear: assert property (
        wr_en && a_addr == OFF_IRQ_FLG && edge_hit[0] == 8'h00
        |=> (flag[0] & $past(hwdata[7:0])) == 8'h00)
        else $error("write one did not clear flag");
    chk_wake_req: assert property (
        (flag[1] & en[1]) != 8'h00 |-> wake_request && irq_h)
        else $error("pending flag without wake request");
    chk_led_force: assert property (
        status_led_enable |-> l_pad.oe[4:0] == 5'h1f)
        else $error("led pins not forced to output");
    chk_od_no_high: assert property (
        (l_pad.oe & od_eff & l_pad.out) == 7'h00)
        else $error("open drain pin driven high");
    chk_pushpull_pull: assert property (
        (l_pad.oe & ~od_eff & (l_pad.pull_up | l_pad.pull_down)) == 7'h00)
        else $error("pull active on push-pull output");
    chk_latch_read: assert property (
        rd_wait && a_addr == OFF_L_LATCH
        |=> hrdata[6:0] == (($past(dir) & $past(latch)) | (~$past(dir) & $past(l_sync))))
        else $error("latch readback wrong");
    chk_run_tick: assert property (
        !stop_mode |-> tick)
        else $error("filter not sampling in run mode");
    chk_rc_gated: assert property (
        stop_mode && !rc_osc_run |=> rc_cnt == 8'h00)
        else $error("rc divider ran while idle");
    chk_filter_min: assert property (
        !stop_mode && edge_hit[0][0] |-> $past(irq_sync[0][0] ~^ pol[0][0], 3))
        else $error("edge accepted after short pulse");

    cov_g_edge:    cover property (edge_hit[0] != 8'h00);
    cov_read_wait: cover property (rd_wait ##1 hreadyout);
    cov_stop_tick: cover property (stop_mode && tick);

endmodule : pgi_port_ctrl

// [include/pgi_pkg.sv]
// shared constants and types for the port pin control block
package pgi_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_L_LATCH = 8'h00;
    localparam logic [7:0] OFF_L_INPUT = 8'h04;
    localparam logic [7:0] OFF_L_DIR   = 8'h08;
    localparam logic [7:0] OFF_L_DRIVE = 8'h0c;
    localparam logic [7:0] OFF_L_PE    = 8'h10;
    localparam logic [7:0] OFF_L_PPS   = 8'h14;
    localparam logic [7:0] OFF_L_OD    = 8'h18;
    // per irq port p: enable, polarity, flag at base + 0x10*p
    localparam logic [7:0] OFF_IRQ_EN  = 8'h20;
    localparam logic [7:0] OFF_IRQ_POL = 8'h24;
    localparam logic [7:0] OFF_IRQ_FLG = 8'h28;
    localparam logic [7:0] OFF_IRQ_STP = 8'h10;

    // ------------------------------------------------------------
    // pin masks and reset values
    // ------------------------------------------------------------
    localparam logic [2:0][7:0] IRQ_MASK = {8'hcf, 8'h7f, 8'hff};
    localparam logic [6:0]      L_PE_RST = 7'h7f;
    localparam logic [6:0]      LED_MASK = 7'h1f;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int RC_PERIOD_NS  = 2000;
    localparam int RC_DIV        = RC_PERIOD_NS / CLK_PERIOD_NS;
    localparam int FILT_N        = 4;

    // ------------------------------------------------------------
    // pad control of the seven port l pins
    // ------------------------------------------------------------
    typedef struct packed {
        logic [6:0] oe;
        logic [6:0] out;
        logic [6:0] reduced;
        logic [6:0] pull_up;
        logic [6:0] pull_down;
    } pgi_pad_t;

endpackage : pgi_pkg

// [test/pgi_pin_model.sv]
// outside world of the seven port l pins: external drivers, pulls and floating pins
`timescale 1ns/10ps
module pgi_pin_model
    import pgi_pkg::*;
(
    input  wire logic       hclk,
    input  wire pgi_pad_t   l_pad,
    input  wire logic [6:0] ext_en,
    input  wire logic [6:0] ext_val,
    output logic [6:0]      l_pin_in
);
    // ------------------------------------------------------------
    // pin resolution
    // ------------------------------------------------------------
    // a floating pin toggles every cycle so a tool default never looks like a match
    logic [6:0] float_q = 7'h00;
    always @(posedge hclk) float_q <= ~float_q;
    always_comb begin
        for (int i = 0; i < 7; i++) begin
            if (l_pad.oe[i]) l_pin_in[i] = l_pad.out[i];
            else if (ext_en[i]) l_pin_in[i] = ext_val[i];
            else if (l_pad.pull_up[i]) l_pin_in[i] = 1'b1;
            else if (l_pad.pull_down[i]) l_pin_in[i] = 1'b0;
            else l_pin_in[i] = float_q[i];
        end
    end
endmodule : pgi_pin_model

// [test/port_pin_control_with_edge_wakeup_tb_top.sv]
// self-checking bench of the port pin control block
`timescale 1ns/10ps
module port_pin_control_with_edge_wakeup_tb_top;
    import pgi_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, d;
    logic [1:0]  htrans = 2'h0, two_wire_drive_low = 2'h0, port_j_upper_oe, port_j_upper_pull_up;
    logic [2:0]  hsize = 3'h2;
    logic        hreadyout, hresp, rc_osc_run, irq_g, irq_h, irq_j, wake_request;
    logic [6:0]  l_pin_in, l_periph_own = 7'h0, l_periph_out = 7'h0, l_periph_oe = 7'h0;
    logic [6:0]  ext_en = 7'h7f, ext_val = 7'h2a, h_pin_in = 7'h7f;
    logic        status_led_enable = 1'b0, two_wire_en = 1'b0, stop_mode = 1'b0;
    logic [4:0]  led_pins = 5'h13;
    logic [7:0]  g_pin_in = 8'h00, j_pin_in = 8'h00;
    pgi_pad_t    l_pad;
    int          n_errors = 0, num_checks = 0, cycles = 0;
    // port j interrupt registers sit two port strides above port g
    localparam logic [7:0] J_BASE = OFF_IRQ_STP + OFF_IRQ_STP;
    always #5 hclk = ~hclk;
    pgi_port_ctrl u_pgi_port_ctrl (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .l_pin_in(l_pin_in),
        .l_pad(l_pad), .l_periph_own(l_periph_own), .l_periph_out(l_periph_out),
        .l_periph_oe(l_periph_oe), .status_led_enable(status_led_enable), .led_pins(led_pins),
        .g_pin_in(g_pin_in), .h_pin_in(h_pin_in), .j_pin_in(j_pin_in),
        .two_wire_en(two_wire_en), .two_wire_drive_low(two_wire_drive_low),
        .port_j_upper_oe(port_j_upper_oe), .port_j_upper_pull_up(port_j_upper_pull_up),
        .stop_mode(stop_mode), .rc_osc_run(rc_osc_run), .irq_g(irq_g), .irq_h(irq_h),
        .irq_j(irq_j), .wake_request(wake_request));
    pgi_pin_model u_pgi_pin_model (.hclk(hclk), .l_pad(l_pad), .ext_en(ext_en),
        .ext_val(ext_val), .l_pin_in(l_pin_in));
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic give_verdict;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : give_verdict
    // a hang counts as a mismatch; the longest scenario needs about 4000 cycles
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            give_verdict();
        end
    end
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic ahb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        hwrite <= wr;
        htrans <= 2'h2;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        d = hrdata;
    endtask : ahb_xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        ahb_xfer(1'b1, a, wd);
    endtask : wr
    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        ahb_xfer(1'b0, a, 32'h0);
        chk(nm, exp, d);
    endtask : rd_chk
    task automatic settle(input int n);
        repeat (n) @(posedge hclk);
    endtask : settle
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset_state;
        chk("pull_up", 32'h7f, l_pad.pull_up);
        chk("oe", 32'h0, l_pad.oe);
        chk("j_pull", 32'h3, port_j_upper_pull_up);
        chk("hresp", 32'h0, hresp);
        rd_chk("pe", OFF_L_PE, 32'h7f);
        rd_chk("dir", OFF_L_DIR, 32'h0);
        rd_chk("g_en", OFF_IRQ_EN, 32'h0);
        wr(8'hfc, 32'hffffffff);
        rd_chk("unmapped", 8'hfc, 32'h0);
    endtask : t_reset_state
    task automatic t_dir_latch;
        wr(OFF_L_LATCH, 32'h55);
        wr(OFF_L_DRIVE, 32'h7f);
        wr(OFF_L_DIR, 32'h0f);
        rd_chk("dir_rb", OFF_L_DIR, 32'h0f);
        settle(3); // readback may lag the direction change by two cycles
        chk("oe", 32'h0f, l_pad.oe);
        chk("out", 32'h05, l_pad.out & l_pad.oe);
        chk("reduced", 32'h0f, l_pad.reduced);
        rd_chk("latch_rd", OFF_L_LATCH, 32'h25);
        rd_chk("input_rd", OFF_L_INPUT, 32'h25);
        wr(OFF_L_INPUT, 32'h7f);
        rd_chk("input_ro", OFF_L_INPUT, 32'h25);
    endtask : t_dir_latch
    task automatic t_led_periph;
        wr(OFF_L_DIR, 32'h0);
        status_led_enable <= 1'b1;
        l_periph_own      <= 7'h40;
        l_periph_oe       <= 7'h40;
        l_periph_out      <= 7'h40;
        settle(2);
        chk("led_oe", 32'h5f, l_pad.oe);
        chk("led_out", 32'h53, l_pad.out & l_pad.oe);
        wr(OFF_L_DIR, 32'h7f);
        l_periph_oe <= 7'h00;
        settle(2);
        chk("per_oe", 32'h1f, l_pad.oe & 7'h5f);
        status_led_enable <= 1'b0;
        l_periph_own      <= 7'h00;
    endtask : t_led_periph
    task automatic t_pulls_od;
        wr(OFF_L_DIR, 32'h0);
        wr(OFF_L_PPS, 32'h0f);
        settle(2);
        chk("pdn_in", 32'h0f, l_pad.pull_down);
        chk("pup_in", 32'h70, l_pad.pull_up);
        wr(OFF_L_PPS, 32'h0);
        wr(OFF_L_OD, 32'h70);
        wr(OFF_L_LATCH, 32'h50);
        wr(OFF_L_DIR, 32'h7f);
        settle(2);
        chk("od_oe", 32'h2f, l_pad.oe);
        chk("od_out", 32'h0, l_pad.out & l_pad.oe);
        chk("od_pup", 32'h70, l_pad.pull_up);
        chk("pp_pdn", 32'h0, l_pad.pull_down);
    endtask : t_pulls_od
    task automatic t_edges;
        wr(OFF_IRQ_EN, 32'h01);
        wr(OFF_IRQ_POL, 32'h01);
        settle(10);
        g_pin_in <= 8'h01;
        settle(3);
        g_pin_in <= 8'h00;
        settle(20);
        rd_chk("g_short", OFF_IRQ_FLG, 32'h0);
        g_pin_in <= 8'h01;
        settle(20);
        rd_chk("g_flag", OFF_IRQ_FLG, 32'h01);
        chk("irq_g", 32'h1, irq_g);
        chk("wake", 32'h1, wake_request);
        wr(OFF_IRQ_FLG, 32'h0);
        rd_chk("g_keep", OFF_IRQ_FLG, 32'h01);
        wr(OFF_IRQ_FLG, 32'h01);
        rd_chk("g_clr", OFF_IRQ_FLG, 32'h0);
        chk("irq_g_off", 32'h0, irq_g);
        wr(OFF_IRQ_EN + OFF_IRQ_STP, 32'h04);
        h_pin_in <= 7'h7b;
        settle(20);
        rd_chk("h_flag", OFF_IRQ_FLG + OFF_IRQ_STP, 32'h04);
        chk("irq_h", 32'h1, irq_h);
        wr(OFF_IRQ_FLG + OFF_IRQ_STP, 32'h04);
        g_pin_in <= 8'h00;
        settle(20);
        rd_chk("g_fall", OFF_IRQ_FLG, 32'h0);
    endtask : t_edges
    task automatic t_stop;
        wr(OFF_IRQ_EN + OFF_IRQ_STP, 32'h0);
        wr(OFF_IRQ_EN, 32'h02);
        wr(OFF_IRQ_POL, 32'h02);
        stop_mode <= 1'b1;
        settle(2);
        chk("rc_run", 32'h1, rc_osc_run);
        settle(1000);
        g_pin_in <= 8'h02; // 3.2 us pulse must be dropped
        settle(320);
        g_pin_in <= 8'h00;
        settle(1000);
        chk("stop_short", 32'h0, irq_g);
        g_pin_in <= 8'h02; // 12 us pulse must be taken
        settle(1200);
        g_pin_in <= 8'h00;
        settle(400);
        chk("stop_irq", 32'h1, irq_g);
        chk("rc_idle", 32'h0, rc_osc_run);
        stop_mode <= 1'b0;
        wr(OFF_IRQ_FLG, 32'h02);
    endtask : t_stop
    task automatic t_two_wire;
        two_wire_en        <= 1'b1;
        two_wire_drive_low <= 2'h2;
        settle(2);
        chk("tw_oe", 32'h2, port_j_upper_oe);
        two_wire_en <= 1'b0;
        settle(2);
        chk("tw_pull", 32'h3, port_j_upper_pull_up);
    endtask : t_two_wire
    task automatic t_j_edge;
        wr(OFF_IRQ_EN + J_BASE, 32'hff);
        rd_chk("j_en", OFF_IRQ_EN + J_BASE, 32'hcf);
        wr(OFF_IRQ_POL + J_BASE, 32'h40);
        settle(10);
        j_pin_in <= 8'h40;
        settle(20);
        rd_chk("j_flag", OFF_IRQ_FLG + J_BASE, 32'h40);
        chk("irq_j", 32'h1, irq_j);
        chk("j_wake", 32'h1, wake_request);
        wr(OFF_IRQ_FLG + J_BASE, 32'h40);
        rd_chk("j_clr", OFF_IRQ_FLG + J_BASE, 32'h0);
        chk("hresp_end", 32'h0, hresp);
    endtask : t_j_edge
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        settle(10);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset_state();
        t_dir_latch();
        t_led_periph();
        t_pulls_od();
        t_edges();
        t_stop();
        t_two_wire();
        t_j_edge();
        give_verdict();
    end
endmodule : port_pin_control_with_edge_wakeup_tb_top
